//--- logic/csa_top.sv
`timescale 1ns/10ps
`default_nettype none
module csa_top (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic ce,
    // Pre-scaled VCO clock (second domain)
    input wire logic vco_clk,
    // Crystal reference clock pin, sampled
    input wire logic ref_clk_pin,
    // Processor configuration
    input wire csa_pkg::csa_cfg_t cfg,
    // Phase error estimator per symbol
    input wire logic sym_valid,
    input wire logic [7:0] phase_metric,
    input wire logic [7:0] freq_metric,
    // Status and sweep output
    output csa_pkg::csa_status_t status,
    output logic meas_done,
    output logic [15:0] sweep_value
);
    import csa_pkg::*;

    // ==========================================================
    // Reference pin synchroniser and edge detect
    logic ref_s1_r, ref_s2_r, ref_d_r;
    logic ref_edge;
    // Measurement gate level, crosses to VCO domain
    logic gate_r, gate_nxt;
    // VCO domain state
    logic vg_s1_r, vg_s2_r, vg_d_r;
    logic [VCO_CNT_W-1:0] vcnt_r, vcnt_nxt;
    logic [VCO_CNT_W-1:0] vhold_r, vhold_nxt;
    logic vdone_tgl_r, vdone_tgl_nxt;
    // Result toggle back in mclk domain
    logic dn_s1_r, dn_s2_r, dn_d_r;
    logic result_evt;

    // Reference pin passes two flops first
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_d_r <= 1'b0;
            dn_s1_r <= 1'b0;
            dn_s2_r <= 1'b0;
            dn_d_r <= 1'b0;
        end else if (ce) begin
            ref_s1_r <= ref_clk_pin;
            ref_s2_r <= ref_s1_r;
            ref_d_r <= ref_s2_r;
            dn_s1_r <= vdone_tgl_r;
            dn_s2_r <= dn_s1_r;
            dn_d_r <= dn_s2_r;
        end
    end
    assign ref_edge = ref_s2_r & ~ref_d_r;
    // Count is stable in vhold_r when toggle is seen
    assign result_evt = dn_s2_r ^ dn_d_r;

    // ==========================================================
    // VCO-domain counter
    // Only the synced gate is read; the VCO clock may stop,
    // so a stalled counter simply never reports.
    always_comb begin
        vcnt_nxt = vcnt_r;
        vhold_nxt = vhold_r;
        vdone_tgl_nxt = vdone_tgl_r;
        if (vg_s2_r && !vg_d_r) begin
            vcnt_nxt = '0;
        end else if (vg_s2_r) begin
            // Saturate rather than wrap
            if (vcnt_r != {VCO_CNT_W{1'b1}})
                vcnt_nxt = vcnt_r + 16'h0001;
        end else if (vg_d_r) begin
            vhold_nxt = vcnt_r;
            vdone_tgl_nxt = ~vdone_tgl_r;
        end
    end

    always_ff @(posedge vco_clk or negedge arst_n) begin
        if (!arst_n) begin
            vg_s1_r <= 1'b0;
            vg_s2_r <= 1'b0;
            vg_d_r <= 1'b0;
            vcnt_r <= '0;
            vhold_r <= '0;
            vdone_tgl_r <= 1'b0;
        end else begin
            vg_s1_r <= gate_r;
            vg_s2_r <= vg_s1_r;
            vg_d_r <= vg_s2_r;
            vcnt_r <= vcnt_nxt;
            vhold_r <= vhold_nxt;
            vdone_tgl_r <= vdone_tgl_nxt;
        end
    end

    // ==========================================================
    // Measurement sequencer and sweep direction
    csa_state_t state_r, state_nxt;
    logic [REF_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;
    logic dir_r, dir_nxt;
    logic [VCO_CNT_W-1:0] count_r, count_nxt;
    logic done_r, done_nxt;
    logic manual_mode;

    // both limits zero means no prescaled clock
    assign manual_mode = (cfg.sweep_upper_limit == 16'h0000) &&
                         (cfg.sweep_lower_limit == 16'h0000);

    always_comb begin
        state_nxt = state_r;
        ref_cnt_nxt = ref_cnt_r;
        gate_nxt = gate_r;
        dir_nxt = dir_r;
        count_nxt = count_r;
        done_nxt = 1'b0;
        if (manual_mode) begin
            dir_nxt = cfg.manual_sweep_direction;
        end
        case (state_r)
            CSA_IDLE: begin
                // Measure only while sweeping with a clock
                if (cfg.sweep_run && !manual_mode) begin
                    ref_cnt_nxt = {cfg.reference_period_count,
                                   {REF_UNIT_SHIFT{1'b0}}};
                    gate_nxt = 1'b1;
                    state_nxt = CSA_GATE;
                end
            end
            CSA_GATE: begin
                if (ref_cnt_r == '0) begin
                    gate_nxt = 1'b0;
                    state_nxt = CSA_WAIT;
                end else if (ref_edge) begin
                    ref_cnt_nxt = ref_cnt_r - 14'h0001;
                end
            end
            CSA_WAIT: begin
                // Limits changed to zero: abandon compare
                if (manual_mode) begin
                    state_nxt = CSA_IDLE;
                end else if (result_evt) begin
                    count_nxt = vhold_r;
                    done_nxt = 1'b1;
                    state_nxt = CSA_IDLE;
                    if (vhold_r < cfg.sweep_lower_limit) begin
                        dir_nxt = DIR_UP;
                    end else if (vhold_r > cfg.sweep_upper_limit) begin
                        dir_nxt = DIR_DOWN;
                    end else begin
                        dir_nxt = dir_r;
                    end
                end
            end
            default: begin
                state_nxt = CSA_IDLE;
                gate_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= CSA_IDLE;
            ref_cnt_r <= '0;
            gate_r <= 1'b0;
            dir_r <= DIR_UP;
            count_r <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            ref_cnt_r <= ref_cnt_nxt;
            gate_r <= gate_nxt;
            dir_r <= dir_nxt;
            count_r <= count_nxt;
            done_r <= done_nxt;
        end
    end

    // ==========================================================
    // Sweep generator
    // Rate is added or subtracted per cycle by dir_r; the accumulator wraps, which is
    // acceptable while limits are set and turn it back; in manual mode nothing does.
    logic [SWEEP_ACC_W-1:0] acc_r, acc_nxt;
    logic [SWEEP_ACC_W-1:0] rate_ext;

    assign rate_ext = {{(SWEEP_ACC_W-8){1'b0}}, cfg.sweep_rate_value};

    always_comb begin
        acc_nxt = acc_r;
        // hold sweep while loop is open
        if (cfg.sweep_run && !cfg.loop_open_request) begin
            if (dir_r == DIR_UP)
                acc_nxt = acc_r + rate_ext;
            else
                acc_nxt = acc_r - rate_ext;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            acc_r <= SWEEP_ACC_RST;
        else if (ce)
            acc_r <= acc_nxt;
    end

    // ==========================================================
    // Phase and frequency lock detectors
    logic [LOCK_PER_W-1:0] per_r, per_nxt;
    logic [LOCK_SUM_W-1:0] psum_r, psum_nxt;
    logic [LOCK_SUM_W-1:0] fsum_r, fsum_nxt;
    logic plock_r, plock_nxt;
    logic flock_r, flock_nxt;
    logic [LOCK_PER_W-1:0] per_last;
    logic [LOCK_SUM_W-1:0] psum_all, fsum_all;
    logic [7:0] pavg, favg;

    assign per_last = cfg.short_period_sel ? SHORT_PER_LAST
                                           : LONG_PER_LAST;
    // Sums include the current symbol, so the deciding symbol
    // is the last of the window and each window is full length
    assign psum_all = psum_r + {10'h000, phase_metric};
    assign fsum_all = fsum_r + {10'h000, freq_metric};
    assign pavg = cfg.short_period_sel ? psum_all[15:8] : psum_all[17:10];
    assign favg = cfg.short_period_sel ? fsum_all[15:8] : fsum_all[17:10];

    always_comb begin
        per_nxt = per_r;
        psum_nxt = psum_r;
        fsum_nxt = fsum_r;
        plock_nxt = plock_r;
        flock_nxt = flock_r;
        if (cfg.loop_open_request) begin
            // open loop drops lock, restarts estimates
            per_nxt = '0;
            psum_nxt = '0;
            fsum_nxt = '0;
            plock_nxt = 1'b0;
            flock_nxt = 1'b0;
        end else if (sym_valid) begin
            if (per_r >= per_last) begin
                plock_nxt = (pavg >= cfg.phase_lock_threshold);
                flock_nxt = (favg <= FLOCK_THRESHOLD);
                per_nxt = '0;
                psum_nxt = '0;
                fsum_nxt = '0;
            end else begin
                per_nxt = per_r + 10'h001;
                psum_nxt = psum_all;
                fsum_nxt = fsum_all;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            per_r <= '0;
            psum_r <= '0;
            fsum_r <= '0;
            plock_r <= 1'b0;
            flock_r <= 1'b0;
        end else if (ce) begin
            per_r <= per_nxt;
            psum_r <= psum_nxt;
            fsum_r <= fsum_nxt;
            plock_r <= plock_nxt;
            flock_r <= flock_nxt;
        end
    end

    // ==========================================================
    // Registered outputs
    csa_status_t status_r, status_nxt;
    logic [SWEEP_OUT_W-1:0] sweep_out_r;

    always_comb begin
        // New count appears together with the strobe
        status_nxt.vco_count = count_nxt;
        status_nxt.sweep_dir = dir_r;
        status_nxt.phase_lock_flag = plock_r;
        status_nxt.frequency_lock_flag = flock_r;
        status_nxt.false_lock = plock_r & ~flock_r;
        status_nxt.loop_open = cfg.loop_open_request;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= '0;
            sweep_out_r <= SWEEP_ACC_RST[SWEEP_ACC_W-1 -: SWEEP_OUT_W];
        end else if (ce) begin
            status_r <= status_nxt;
            sweep_out_r <= acc_r[SWEEP_ACC_W-1 -: SWEEP_OUT_W];
        end
    end

    assign status = status_r;
    assign meas_done = done_r;
    assign sweep_value = sweep_out_r;
endmodule // csa_top
`default_nettype wire

//--- logic/csa_pkg.sv
//==========================================================
`default_nettype none
package csa_pkg;
    // ==========================================================
    // Sizes and fixed values
    localparam int unsigned REF_UNIT_SHIFT = 10;
    localparam int unsigned REF_CNT_W = 14;
    localparam int unsigned VCO_CNT_W = 16;
    localparam int unsigned SWEEP_ACC_W = 24;
    localparam int unsigned SWEEP_OUT_W = 16;
    localparam int unsigned LOCK_SUM_W = 18;
    localparam int unsigned LOCK_PER_W = 10;
    // Long period 1024 symbols, short 256
    localparam logic [LOCK_PER_W-1:0] LONG_PER_LAST = 10'h3FF;
    localparam logic [LOCK_PER_W-1:0] SHORT_PER_LAST = 10'h0FF;
    localparam logic [7:0] FLOCK_THRESHOLD = 8'h10;
    localparam logic [SWEEP_ACC_W-1:0] SWEEP_ACC_RST = 24'h800000;
    localparam logic DIR_UP = 1'b1;
    localparam logic DIR_DOWN = 1'b0;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CSA_IDLE = 2'b00,
        CSA_GATE = 2'b01,
        CSA_WAIT = 2'b10
    } csa_state_t;

    // Processor configuration bits, same clock as mclk
    typedef struct packed {
        logic [15:0] sweep_upper_limit;
        logic [15:0] sweep_lower_limit;
        logic [3:0] reference_period_count;
        logic [7:0] sweep_rate_value;
        logic manual_sweep_direction;
        logic sweep_run;
        logic short_period_sel;
        logic [7:0] phase_lock_threshold;
        logic loop_open_request;
    } csa_cfg_t;

    // Status returned to the processor
    typedef struct packed {
        logic [15:0] vco_count;
        logic sweep_dir;
        logic phase_lock_flag;
        logic frequency_lock_flag;
        logic false_lock;
        logic loop_open;
    } csa_status_t;
endpackage
`default_nettype wire

//--- verif/csa_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module csa_top_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Watched ports
    input wire csa_pkg::csa_cfg_t cfg,
    input wire csa_pkg::csa_status_t status,
    input wire logic meas_done,
    input wire logic [15:0] sweep_value
);
    import csa_pkg::*;
    // Both limits zero: no count is used
    logic manual;
    logic lo;
    logic hi;
    assign manual = cfg.sweep_upper_limit == 16'h0000
        && cfg.sweep_lower_limit == 16'h0000;
    assign lo = status.vco_count < cfg.sweep_lower_limit;
    assign hi = status.vco_count > cfg.sweep_upper_limit;
    // ==========================================
    // Properties, one domain
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_pulse; meas_done |=> !meas_done; endproperty
    a_pulse: assert property (p_pulse)
        else $error("count strobe held too long");
    property p_up; meas_done && lo |=> status.sweep_dir; endproperty
    a_up: assert property (p_up)
        else $error("low count did not turn sweep up");
    property p_down; meas_done && hi |=> !status.sweep_dir; endproperty
    a_down: assert property (p_down)
        else $error("high count did not turn sweep down");
    property p_keep;
        meas_done && !lo && !hi |=> $stable(status.sweep_dir);
    endproperty
    a_keep: assert property (p_keep)
        else $error("in-band count changed direction");
    // Four cycles allow for the dir_r and status register lag
    property p_manual;
        (manual && $stable(cfg.manual_sweep_direction)) [*4]
        |-> status.sweep_dir == cfg.manual_sweep_direction;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual direction not followed");
    property p_false;
        status.false_lock == (status.phase_lock_flag
            && !status.frequency_lock_flag);
    endproperty
    a_false: assert property (p_false)
        else $error("false lock flag wrong");
    property p_clr;
        cfg.loop_open_request [*4]
        |-> !status.phase_lock_flag && !status.frequency_lock_flag;
    endproperty
    a_clr: assert property (p_clr)
        else $error("lock flags kept while loop open");
    property p_halt;
        (!cfg.sweep_run || cfg.loop_open_request) [*3]
        |-> $stable(sweep_value);
    endproperty
    a_halt: assert property (p_halt)
        else $error("sweep moved while stopped");
    c_low: cover property (meas_done && lo);
    c_false: cover property (status.false_lock);
    c_manual: cover property (manual && !status.sweep_dir);
endmodule // csa_top_asserts
bind csa_top csa_top_asserts u_csa_top_asserts (
    .mclk(mclk),
    .arst_n(arst_n),
    .cfg(cfg),
    .status(status),
    .meas_done(meas_done),
    .sweep_value(sweep_value)
);
`default_nettype wire

//--- verif/csa_vco_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Prescaler and crystal outside the block
module csa_vco_model (
    // Prescaled clock gate
    input wire logic run,
    // Clocks toward the block
    output logic vco_clk,
    output logic ref_clk_pin
);
    // Prescaled clock, 12 ns, parked low when stopped
    initial vco_clk = 1'b0;
    always #6 vco_clk = run ? ~vco_clk : 1'b0;
    // Crystal runs free, slower than the prescaled clock
    initial ref_clk_pin = 1'b0;
    always #20 ref_clk_pin = ~ref_clk_pin;
endmodule // csa_vco_model
`default_nettype wire

//--- verif/csa_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Compare and count
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
end
module csa_top_tb;
    import csa_pkg::*;
    // Stimulus and observed signals
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic vco_run = 1'b1;
    logic ce = 1'b1;
    logic vco_clk;
    logic ref_clk_pin;
    csa_cfg_t cfg = '0;
    logic sym_valid = 1'b0;
    logic [7:0] phase_metric = 8'h00;
    logic [7:0] freq_metric = 8'h00;
    csa_status_t status;
    logic meas_done;
    logic [15:0] sweep_value;
    logic [15:0] v0;
    int mismatches = 0;
    int n_compared = 0;
    always #4 mclk = ~mclk;
    csa_vco_model u_csa_vco_model (.run(vco_run), .vco_clk(vco_clk),
        .ref_clk_pin(ref_clk_pin));
    csa_top u_csa_top (.mclk(mclk), .arst_n(arst_n), .ce(ce),
        .vco_clk(vco_clk), .ref_clk_pin(ref_clk_pin), .cfg(cfg),
        .sym_valid(sym_valid), .phase_metric(phase_metric),
        .freq_metric(freq_metric), .status(status),
        .meas_done(meas_done), .sweep_value(sweep_value));
    // ==========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Bounded wait for the next count strobe
    task automatic wait_done;
        int i;
        @(negedge mclk);
        for (i = 0; i < 12000 && meas_done !== 1'b1; i++) @(negedge mclk);
    endtask
    // Two periods under new limits, then judge count and direction
    task automatic t_meas(input logic [3:0] rp, input logic [15:0] lo,
        input logic [15:0] hi, input logic dir, input logic [15:0] cmin);
        @(posedge mclk);
        cfg.reference_period_count <= rp;
        cfg.sweep_lower_limit <= lo;
        cfg.sweep_upper_limit <= hi;
        wait_done;
        wait_done;
        `CHK(meas_done, 1'b1)
        `CHK(status.vco_count > cmin && status.vco_count < cmin + 16'h80, 1'b1)
        cyc(2);
        @(negedge mclk);
        `CHK(status.sweep_dir, dir)
        $display("measure test done");
    endtask
    // Sweep with the prescaled clock stopped
    task automatic t_manual(input logic dir, input logic [7:0] rate,
        input logic [15:0] step);
        @(posedge mclk);
        vco_run <= 1'b0;
        cfg.sweep_lower_limit <= 16'h0000;
        cfg.sweep_upper_limit <= 16'h0000;
        cfg.manual_sweep_direction <= dir;
        cfg.sweep_rate_value <= rate;
        cyc(4);
        @(negedge mclk);
        `CHK(status.sweep_dir, dir)
        v0 = sweep_value;
        cyc(256);
        @(negedge mclk);
        `CHK(sweep_value, v0 + step)
        `CHK(meas_done, 1'b0)
        // Clock enable low freezes the sweep
        @(posedge mclk);
        ce <= 1'b0;
        @(negedge mclk);
        v0 = sweep_value;
        cyc(20);
        @(negedge mclk);
        `CHK(sweep_value, v0)
        @(posedge mclk);
        ce <= 1'b1;
        $display("manual sweep test done");
    endtask
    // Feed n symbols, then judge both lock flags
    task automatic t_lock(input logic sp, input int n,
        input logic [7:0] thr, input logic [7:0] pm,
        input logic [7:0] fm, input logic pl, input logic fl);
        int i;
        @(posedge mclk);
        cfg.short_period_sel <= sp;
        cfg.phase_lock_threshold <= thr;
        for (i = 0; i < n; i++) begin
            @(posedge mclk);
            sym_valid <= 1'b1;
            phase_metric <= pm;
            freq_metric <= fm;
            @(posedge mclk);
            sym_valid <= 1'b0;
        end
        cyc(3);
        @(negedge mclk);
        `CHK({status.phase_lock_flag, status.frequency_lock_flag}, {pl, fl})
        `CHK(status.false_lock, pl & ~fl)
        $display("lock test done");
    endtask
    // Open or stop, then the sweep must hold still
    task automatic t_hold(input logic op);
        @(posedge mclk);
        cfg.loop_open_request <= op;
        cfg.sweep_run <= op;
        cyc(4);
        @(negedge mclk);
        v0 = sweep_value;
        `CHK(status.loop_open, op)
        `CHK(status.phase_lock_flag, ~op)
        cyc(20);
        @(negedge mclk);
        `CHK(sweep_value, v0)
        @(posedge mclk);
        cfg.loop_open_request <= 1'b0;
        $display("hold test done");
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        cyc(7);
        @(negedge mclk);
        `CHK({status, sweep_value}, {21'h0, 16'h8000})
        @(posedge mclk);
        arst_n <= 1'b1;
        cfg.sweep_run <= 1'b1;
        cfg.sweep_rate_value <= 8'h21;
        t_meas(4'h1, 16'h0100, 16'h0200, 1'b0, 16'h0D00);
        t_meas(4'h1, 16'h0C00, 16'h0F00, 1'b0, 16'h0D00);
        t_meas(4'h2, 16'h2000, 16'h3000, 1'b1, 16'h1A80);
        t_manual(1'b0, 8'h01, 16'hFFFF);
        t_manual(1'b1, 8'hFF, 16'h00FF);
        t_lock(1'b1, 257, 8'h48, 8'h48, 8'h11, 1'b1, 1'b0);
        t_hold(1'b1);
        t_lock(1'b0, 1025, 8'h1F, 8'h1F, 8'h10, 1'b1, 1'b1);
        t_hold(1'b0);
        end_sim;
    end
    // Watchdog, about twice the expected run
    initial begin
        cyc(90000);
        mismatches++;
        end_sim;
    end
endmodule // csa_top_tb
`default_nettype wire
